// file: src/dso_pkg.sv
// Constants for the drive status and mode object bank.
// Summary of operation
// - A 16-bit read-only status word reports the present drive state.
// - Bits 0,1,2,3,5,6 carry ready, switched on, enabled, fault, quick stop, disabled.
// - Each drive state has a fixed code in status bits 6, 5 and 3 to 0.
// - Status bit 4 is set while the power section is supplied.
// - Status bit 7, the warning flag, is unused and reads zero.
// - Status bit 9 shows remote mode, accepting network commands.
// - Status bit 10 shows reference reached, or quick stop or halt active.
// - Status bit 11, internal limit active, is unused and reads zero.
// - Bits 12 and 13 are mode specific; bits 8, 14 and 15 reserved.
// - Mode selector is signed 8-bit; only codes 1,3,4,8,9 are legal.
// - Mode display reports the active mode with the same code set.
// - Supported-modes bitmap assigns one bit per drive mode.
// - Supported-modes bitmap reads the constant 0Dh and is read-only.
// - Sub-index 0 of both unit arrays reads 02h and is read-only.
// - Encoder increments accept only codes 41h, 42h, 43h and FFh.
// - Encoder motor revolutions accept only the value 1.
// - Encoder resolution is increments divided by motor revolutions.
// - Gear ratio is motor over shaft revolutions; both reset to 01h.
// - Both gear ratio entries accept only the value 1.
// - A fault enters fault reaction, disables drive, then moves to fault.
package dso_pkg;

  // ****************************************************************
  // Object indices and sub-indices
  // ****************************************************************
  localparam logic [15:0] IDX_STATUS   = 16'h6041;
  localparam logic [15:0] IDX_MODE_SEL = 16'h6060;
  localparam logic [15:0] IDX_MODE_REP = 16'h6061;
  localparam logic [15:0] IDX_ENC_RES  = 16'h608F;
  localparam logic [15:0] IDX_GEAR     = 16'h6091;
  localparam logic [15:0] IDX_SUPP     = 16'h6502;
  localparam logic [7:0]  SUB_COUNT    = 8'h00;
  localparam logic [7:0]  SUB_FIRST    = 8'h01;
  localparam logic [7:0]  SUB_SECOND   = 8'h02;

  // ****************************************************************
  // Status word bit positions
  // ****************************************************************
  localparam int unsigned SB_RDY    = 0;
  localparam int unsigned SB_SWON   = 1;
  localparam int unsigned SB_OPEN   = 2;
  localparam int unsigned SB_FAULT  = 3;
  localparam int unsigned SB_VOLT   = 4;
  localparam int unsigned SB_QSTOP  = 5;
  localparam int unsigned SB_SOD    = 6;
  localparam int unsigned SB_REMOTE = 9;
  localparam int unsigned SB_TGT    = 10;
  localparam int unsigned SB_MS0    = 12;
  localparam int unsigned SB_MS1    = 13;

  // ****************************************************************
  // Mode codes, unit codes and reset values
  // ****************************************************************
  localparam logic [7:0]  MODE_PP   = 8'h01;
  localparam logic [7:0]  MODE_PV   = 8'h03;
  localparam logic [7:0]  MODE_TQ   = 8'h04;
  localparam logic [7:0]  MODE_CSP  = 8'h08;
  localparam logic [7:0]  MODE_CSV  = 8'h09;
  localparam logic [7:0]  MODE_RST  = 8'h01;
  localparam logic [31:0] UNIT_DEG  = 32'h0000_0041;
  localparam logic [31:0] UNIT_MIN  = 32'h0000_0042;
  localparam logic [31:0] UNIT_SEC  = 32'h0000_0043;
  localparam logic [31:0] UNIT_INT  = 32'h0000_00FF;
  localparam logic [31:0] ONE_RST   = 32'h0000_0001;
  localparam logic [7:0]  LAST_SUB  = 8'h02;
  localparam logic [31:0] SUPP_MAP  = 32'h0000_000D;

  // ****************************************************************
  // Access answer codes
  // ****************************************************************
  localparam logic [1:0] ANS_OK      = 2'h0;
  localparam logic [1:0] ANS_NOOBJ   = 2'h1;
  localparam logic [1:0] ANS_RDONLY  = 2'h2;
  localparam logic [1:0] ANS_RANGE   = 2'h3;

  typedef enum logic [2:0] {
    DSO_NOT_READY, DSO_SW_DISABLED, DSO_READY, DSO_SWITCHED_ON,
    DSO_OP_ENABLED, DSO_QSTOP, DSO_FLT_REACT, DSO_FAULT
  } dso_state_e;

endpackage : dso_pkg

// file: src/dso_unit_check.sv
// Legality check for one unit-conversion entry write.
`timescale 1ns/1ps
module dso_unit_check #(
  parameter bit ALLOW_UNITS = 1'b0
) (
  input  wire logic [31:0] wdata,
  output wire logic        legal
);

  // Unit entries take one of four codes; ratio entries take only one.
  // unit code check
  wire unit_ok = (wdata == dso_pkg::UNIT_DEG) || (wdata == dso_pkg::UNIT_MIN) ||
                 (wdata == dso_pkg::UNIT_SEC) || (wdata == dso_pkg::UNIT_INT);
  wire one_ok  = (wdata == dso_pkg::ONE_RST);
  assign legal = ALLOW_UNITS ? unit_ok : one_ok;

endmodule : dso_unit_check

// file: src/dso_objects.sv
// Object bank for drive status word, mode objects and unit-conversion arrays.
`timescale 1ns/1ps
module dso_objects (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        REQ,
  input  wire logic        WR,
  input  wire logic [15:0] INDEX,
  input  wire logic [7:0]  SUBIDX,
  input  wire logic [31:0] WDATA,
  output logic             ACK,
  output logic [1:0]       ANSWER,
  output logic [31:0]      RDATA,
  input  wire logic        INIT_DONE,
  input  wire logic        CMD_SHUTDOWN,
  input  wire logic        CMD_SWITCH_ON,
  input  wire logic        CMD_ENABLE,
  input  wire logic        CMD_DISABLE_OP,
  input  wire logic        CMD_DISABLE_V,
  input  wire logic        CMD_QSTOP,
  input  wire logic        CMD_FAULT_RESET,
  input  wire logic        FAULT_DETECT,
  input  wire logic        DISABLE_DONE,
  input  wire logic        POWER_SUPPLIED,
  input  wire logic        REMOTE_MODE,
  input  wire logic        AT_REFERENCE,
  input  wire logic        HALT_ACTIVE,
  input  wire logic [1:0]  MODE_BITS,
  output logic [15:0]      STATUS_WORD,
  output logic [7:0]       MODE_ACTIVE,
  output logic             DRIVE_ENABLE,
  output logic [31:0]      ENC_INCREMENTS,
  output logic [31:0]      ENC_MOTOR_REVS,
  output logic [31:0]      GEAR_MOTOR_REVS,
  output logic [31:0]      GEAR_SHAFT_REVS
);

  // ****************************************************************
  // Drive state machine
  // ****************************************************************
  dso_pkg::dso_state_e state_q;
  dso_pkg::dso_state_e state_d;

  // Fault detection outranks every command outside fault reaction and fault, where only disable done and fault reset act.
  always_comb begin
    state_d = state_q;
    if (FAULT_DETECT && state_q != dso_pkg::DSO_FAULT &&
        state_q != dso_pkg::DSO_FLT_REACT) begin
      state_d = dso_pkg::DSO_FLT_REACT;
    end else begin
      unique case (state_q)
        dso_pkg::DSO_NOT_READY: begin
          if (INIT_DONE) state_d = dso_pkg::DSO_SW_DISABLED;
        end
        dso_pkg::DSO_SW_DISABLED: begin
          if (CMD_SHUTDOWN) state_d = dso_pkg::DSO_READY;
        end
        dso_pkg::DSO_READY: begin
          if (CMD_DISABLE_V || CMD_QSTOP) state_d = dso_pkg::DSO_SW_DISABLED;
          else if (CMD_SWITCH_ON) state_d = dso_pkg::DSO_SWITCHED_ON;
        end
        dso_pkg::DSO_SWITCHED_ON: begin
          if (CMD_DISABLE_V || CMD_QSTOP) state_d = dso_pkg::DSO_SW_DISABLED;
          else if (CMD_SHUTDOWN) state_d = dso_pkg::DSO_READY;
          else if (CMD_ENABLE) state_d = dso_pkg::DSO_OP_ENABLED;
        end
        dso_pkg::DSO_OP_ENABLED: begin
          if (CMD_DISABLE_V) state_d = dso_pkg::DSO_SW_DISABLED;
          else if (CMD_QSTOP) state_d = dso_pkg::DSO_QSTOP;
          else if (CMD_SHUTDOWN) state_d = dso_pkg::DSO_READY;
          else if (CMD_DISABLE_OP) state_d = dso_pkg::DSO_SWITCHED_ON;
        end
        dso_pkg::DSO_QSTOP: begin
          if (CMD_DISABLE_V) state_d = dso_pkg::DSO_SW_DISABLED;
          else if (CMD_ENABLE) state_d = dso_pkg::DSO_OP_ENABLED;
        end
        dso_pkg::DSO_FLT_REACT: begin
          if (DISABLE_DONE) state_d = dso_pkg::DSO_FAULT;
        end
        dso_pkg::DSO_FAULT: begin
          if (CMD_FAULT_RESET) state_d = dso_pkg::DSO_SW_DISABLED;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) state_q <= dso_pkg::DSO_NOT_READY;
    else        state_q <= state_d;
  end

  // ****************************************************************
  // Status word assembly
  // ****************************************************************
  // Low state code, bits 6,5,3..0, per drive state.
  // state encoding
  logic [6:0] code;
  always_comb begin
    unique case (state_q)
      dso_pkg::DSO_NOT_READY:   code = 7'h00;
      dso_pkg::DSO_SW_DISABLED: code = 7'h40;
      dso_pkg::DSO_READY:       code = 7'h21;
      dso_pkg::DSO_SWITCHED_ON: code = 7'h23;
      dso_pkg::DSO_OP_ENABLED:  code = 7'h27;
      dso_pkg::DSO_QSTOP:       code = 7'h07;
      dso_pkg::DSO_FLT_REACT:   code = 7'h0F;
      dso_pkg::DSO_FAULT:       code = 7'h08;
    endcase
  end

  // Unused and reserved bits stay zero; warning and limit are not reported.
  logic [15:0] status_d;
  always_comb begin
    status_d = 16'h0000;
    status_d[dso_pkg::SB_RDY]   = code[0];
    status_d[dso_pkg::SB_SWON]  = code[1];
    status_d[dso_pkg::SB_OPEN]  = code[2];
    status_d[dso_pkg::SB_FAULT] = code[3];
    status_d[dso_pkg::SB_QSTOP] = code[5];
    status_d[dso_pkg::SB_SOD]   = code[6];
    status_d[dso_pkg::SB_VOLT]   = POWER_SUPPLIED;
    status_d[dso_pkg::SB_REMOTE] = REMOTE_MODE;
    status_d[dso_pkg::SB_TGT]    = AT_REFERENCE || HALT_ACTIVE ||
                                   (state_q == dso_pkg::DSO_QSTOP);
    status_d[dso_pkg::SB_MS0] = MODE_BITS[0];
    status_d[dso_pkg::SB_MS1] = MODE_BITS[1];
  end

  // warning and limit bits held at zero by status_d default
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      STATUS_WORD  <= 16'h0000;
      DRIVE_ENABLE <= 1'b0;
    end else begin
      STATUS_WORD  <= status_d;
      DRIVE_ENABLE <= (state_d == dso_pkg::DSO_OP_ENABLED) ||
                      (state_d == dso_pkg::DSO_QSTOP);
    end
  end

  // ****************************************************************
  // Object access decode
  // ****************************************************************
  wire hit_status = (INDEX == dso_pkg::IDX_STATUS)   && (SUBIDX == dso_pkg::SUB_COUNT);
  wire hit_msel   = (INDEX == dso_pkg::IDX_MODE_SEL) && (SUBIDX == dso_pkg::SUB_COUNT);
  wire hit_mrep   = (INDEX == dso_pkg::IDX_MODE_REP) && (SUBIDX == dso_pkg::SUB_COUNT);
  wire hit_supp   = (INDEX == dso_pkg::IDX_SUPP)     && (SUBIDX == dso_pkg::SUB_COUNT);
  wire is_enc     = (INDEX == dso_pkg::IDX_ENC_RES);
  wire is_gear    = (INDEX == dso_pkg::IDX_GEAR);
  wire arr_cnt    = (is_enc || is_gear) && (SUBIDX == dso_pkg::SUB_COUNT);
  wire hit_enc1   = is_enc  && (SUBIDX == dso_pkg::SUB_FIRST);
  wire hit_enc2   = is_enc  && (SUBIDX == dso_pkg::SUB_SECOND);
  wire hit_gear1  = is_gear && (SUBIDX == dso_pkg::SUB_FIRST);
  wire hit_gear2  = is_gear && (SUBIDX == dso_pkg::SUB_SECOND);
  wire hit_any    = hit_status | hit_msel | hit_mrep | hit_supp | arr_cnt |
                    hit_enc1 | hit_enc2 | hit_gear1 | hit_gear2;
  wire hit_ro     = hit_status | hit_supp | arr_cnt | hit_mrep;

  wire mode_ok = (WDATA[7:0] == dso_pkg::MODE_PP)  || (WDATA[7:0] == dso_pkg::MODE_PV) ||
                 (WDATA[7:0] == dso_pkg::MODE_TQ)  || (WDATA[7:0] == dso_pkg::MODE_CSP) ||
                 (WDATA[7:0] == dso_pkg::MODE_CSV);
  wire unit_ok;
  wire one_ok;

  dso_unit_check #(.ALLOW_UNITS(1'b1)) u_unit_chk (
    .wdata (WDATA),
    .legal (unit_ok)
  );

  dso_unit_check #(.ALLOW_UNITS(1'b0)) u_one_chk (
    .wdata (WDATA),
    .legal (one_ok)
  );

  wire val_ok = hit_msel ? mode_ok : (hit_enc1 ? unit_ok : one_ok);

  wire [1:0] wr_ans = !hit_any ? dso_pkg::ANS_NOOBJ :
                      hit_ro   ? dso_pkg::ANS_RDONLY :
                      !val_ok  ? dso_pkg::ANS_RANGE : dso_pkg::ANS_OK;
  wire do_wr = REQ && WR && (wr_ans == dso_pkg::ANS_OK);

  // ****************************************************************
  // Writable objects
  // ****************************************************************
  logic [7:0]  mode_q;
  logic [31:0] enc_inc_q;
  logic [31:0] enc_rev_q;
  logic [31:0] gear_mot_q;
  logic [31:0] gear_sh_q;

  // Stored values change only on an accepted write; refused ones leave them.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q     <= dso_pkg::MODE_RST;
      enc_inc_q  <= dso_pkg::UNIT_INT;
      enc_rev_q  <= dso_pkg::ONE_RST;
      gear_mot_q <= dso_pkg::ONE_RST;
      gear_sh_q  <= dso_pkg::ONE_RST;
    end else if (do_wr) begin
      if (hit_msel)  mode_q     <= WDATA[7:0];
      if (hit_enc1)  enc_inc_q  <= WDATA;
      if (hit_enc2)  enc_rev_q  <= WDATA;
      if (hit_gear1) gear_mot_q <= WDATA;
      if (hit_gear2) gear_sh_q  <= WDATA;
    end
  end

  // ****************************************************************
  // Read data and answer
  // ****************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_status) rd_mux = {16'h0000, STATUS_WORD};
    if (hit_msel || hit_mrep) rd_mux = {{24{mode_q[7]}}, mode_q};
    if (hit_supp)  rd_mux = dso_pkg::SUPP_MAP;
    if (arr_cnt)   rd_mux = {24'h000000, dso_pkg::LAST_SUB};
    if (hit_enc1)  rd_mux = enc_inc_q;
    if (hit_enc2)  rd_mux = enc_rev_q;
    if (hit_gear1) rd_mux = gear_mot_q;
    if (hit_gear2) rd_mux = gear_sh_q;
  end

  // One answer per request, one cycle later; a read answers its data.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACK    <= 1'b0;
      ANSWER <= dso_pkg::ANS_OK;
      RDATA  <= 32'h0000_0000;
    end else begin
      ACK <= REQ;
      if (REQ) begin
        ANSWER <= WR ? wr_ans : (hit_any ? dso_pkg::ANS_OK : dso_pkg::ANS_NOOBJ);
        RDATA  <= WR ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ****************************************************************
  // Registered copies for the drive's own use
  // ****************************************************************
  // resolution factors held as numerator and denominator
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MODE_ACTIVE     <= dso_pkg::MODE_RST;
      ENC_INCREMENTS  <= dso_pkg::UNIT_INT;
      ENC_MOTOR_REVS  <= dso_pkg::ONE_RST;
      GEAR_MOTOR_REVS <= dso_pkg::ONE_RST;
      GEAR_SHAFT_REVS <= dso_pkg::ONE_RST;
    end else begin
      MODE_ACTIVE     <= mode_q;
      ENC_INCREMENTS  <= enc_inc_q;
      ENC_MOTOR_REVS  <= enc_rev_q;
      GEAR_MOTOR_REVS <= gear_mot_q;
      GEAR_SHAFT_REVS <= gear_sh_q;
    end
  end

endmodule : dso_objects

// file: tb/dso_master_model.sv
// Network master model that issues object reads and writes to the object bank.
`timescale 1ns/1ps
module dso_master_model (
  input  wire logic        CLK,
  input  wire logic        ACK,
  input  wire logic [1:0]  ANSWER,
  input  wire logic [31:0] RDATA,
  output logic             REQ,
  output logic             WR,
  output logic [15:0]      INDEX,
  output logic [7:0]       SUBIDX,
  output logic [31:0]      WDATA
);
  // ****************************************************************
  // Access sequencing
  // ****************************************************************
  // The request lines are idle and defined from time zero.
  initial begin
    REQ = 1'b0;
    WR = 1'b0;
    INDEX = 16'h0000;
    SUBIDX = 8'h00;
    WDATA = 32'h0000_0000;
  end

  // legal and illegal codes alike
  // Only the codes a scenario hands in are written, so refusals happen on command.
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [1:0] ans,
                        output logic [31:0] rd);
    int n;
    @(posedge CLK);
    #1;
    REQ = 1'b1;
    WR = w;
    INDEX = idx;
    SUBIDX = sub;
    WDATA = wd;
    @(posedge CLK);
    #1;
    REQ = 1'b0;
    // Released index and write data lines show the inverse, so a stale value cannot match by luck.
    INDEX = ~idx;
    WDATA = ~wd;
    n = 0;
    while (ACK !== 1'b1 && n < 4) begin
      @(posedge CLK);
      #1;
      n++;
    end
    ans = (n < 4) ? ANSWER : 2'bxx;
    rd = RDATA;
  endtask : access
endmodule : dso_master_model

// file: tb/dso_objects_sva.sv
// Port-level assertions for the drive status and mode object bank.
`timescale 1ns/1ps
module dso_objects_chk (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        REQ,
  input wire logic        WR,
  input wire logic [15:0] INDEX,
  input wire logic [7:0]  SUBIDX,
  input wire logic [31:0] WDATA,
  input wire logic        ACK,
  input wire logic [1:0]  ANSWER,
  input wire logic [31:0] RDATA,
  input wire logic        FAULT_DETECT,
  input wire logic        POWER_SUPPLIED,
  input wire logic        AT_REFERENCE,
  input wire logic        HALT_ACTIVE,
  input wire logic [15:0] STATUS_WORD,
  input wire logic [7:0]  MODE_ACTIVE,
  input wire logic        DRIVE_ENABLE
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // Mode selector writes and their legality, decoded once for reuse.
  wire mode_wr = REQ && WR && (INDEX == dso_pkg::IDX_MODE_SEL) && (SUBIDX == 8'h00);
  wire mode_ok = WDATA[7:0] inside {8'h01, 8'h03, 8'h04, 8'h08, 8'h09};
  wire [15:0] st_code = STATUS_WORD & 16'h006F;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_ack_once;
    1'b1 |=> ACK == $past(REQ);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("request not answered once");
  property p_power;
    1'b1 |=> STATUS_WORD[4] == $past(POWER_SUPPLIED);
  endproperty
  a_power: assert property (p_power) else $error("power flag wrong");
  property p_unused;
    !STATUS_WORD[7] && !STATUS_WORD[11];
  endproperty
  a_unused: assert property (p_unused) else $error("unused flag set");
  property p_target;
    (AT_REFERENCE || HALT_ACTIVE) |=> STATUS_WORD[10];
  endproperty
  a_target: assert property (p_target) else $error("target flag missing");
  property p_state_code;
    st_code inside {16'h0000, 16'h0020, 16'h0040, 16'h0060, 16'h0021, 16'h0023,
                    16'h0027, 16'h0007, 16'h000F, 16'h002F, 16'h0008, 16'h0028};
  endproperty
  a_state_code: assert property (p_state_code) else $error("illegal state code");
  property p_enable_state;
    DRIVE_ENABLE |=> st_code inside {16'h0027, 16'h0007};
  endproperty
  a_enable_state: assert property (p_enable_state) else $error("enable outside run");
  property p_fault_entry;
    FAULT_DETECT |-> ##2 STATUS_WORD[3];
  endproperty
  a_fault_entry: assert property (p_fault_entry) else $error("fault not shown");
  property p_mode_report;
    mode_wr && mode_ok |-> ##2 MODE_ACTIVE == $past(WDATA[7:0], 2);
  endproperty
  a_mode_report: assert property (p_mode_report) else $error("mode not reported");
  property p_mode_refuse;
    mode_wr && !mode_ok |=> ANSWER == dso_pkg::ANS_RANGE;
  endproperty
  a_mode_refuse: assert property (p_mode_refuse) else $error("bad mode accepted");
  property p_status_ro;
    REQ && WR && INDEX == dso_pkg::IDX_STATUS && SUBIDX == 8'h00
      |=> ANSWER == dso_pkg::ANS_RDONLY;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status word written");
  property p_supp_map;
    REQ && !WR && INDEX == dso_pkg::IDX_SUPP && SUBIDX == 8'h00 |=> RDATA == 32'h0000_000D;
  endproperty
  a_supp_map: assert property (p_supp_map) else $error("modes map wrong");
endmodule : dso_objects_chk

bind dso_objects dso_objects_chk chk_u (
  .CLK            (CLK),
  .RST_N          (RST_N),
  .REQ            (REQ),
  .WR             (WR),
  .INDEX          (INDEX),
  .SUBIDX         (SUBIDX),
  .WDATA          (WDATA),
  .ACK            (ACK),
  .ANSWER         (ANSWER),
  .RDATA          (RDATA),
  .FAULT_DETECT   (FAULT_DETECT),
  .POWER_SUPPLIED (POWER_SUPPLIED),
  .AT_REFERENCE   (AT_REFERENCE),
  .HALT_ACTIVE    (HALT_ACTIVE),
  .STATUS_WORD    (STATUS_WORD),
  .MODE_ACTIVE    (MODE_ACTIVE),
  .DRIVE_ENABLE   (DRIVE_ENABLE)
);

// file: tb/tb_top.sv
// Self-checking testbench for the drive status and mode object bank.
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, req, wr, ack, init_done, power, remote, at_ref, halt, drive_en;
  logic [8:0]  cmd_v;
  logic [1:0]  answer, mode_bits;
  logic [7:0]  subidx, mode_act;
  logic [15:0] index, status, last_exp;
  logic [31:0] wdata, rdata, enc_inc, enc_mrev, gear_m, gear_s;
  int          err_count;
  int          num_checks;

  // ****************************************************************
  // Design, master model and scenarios
  // ****************************************************************
  // Command vector bits: shutdown, switch on, enable, disable op, disable volt,
  // quick stop, fault reset, fault detect, disable done.
  dso_objects dut_u (
    .CLK(clk), .RST_N(rst_n), .REQ(req), .WR(wr), .INDEX(index), .SUBIDX(subidx),
    .WDATA(wdata), .ACK(ack), .ANSWER(answer), .RDATA(rdata), .INIT_DONE(init_done),
    .CMD_SHUTDOWN(cmd_v[0]), .CMD_SWITCH_ON(cmd_v[1]), .CMD_ENABLE(cmd_v[2]),
    .CMD_DISABLE_OP(cmd_v[3]), .CMD_DISABLE_V(cmd_v[4]), .CMD_QSTOP(cmd_v[5]),
    .CMD_FAULT_RESET(cmd_v[6]), .FAULT_DETECT(cmd_v[7]), .DISABLE_DONE(cmd_v[8]),
    .POWER_SUPPLIED(power), .REMOTE_MODE(remote), .AT_REFERENCE(at_ref),
    .HALT_ACTIVE(halt), .MODE_BITS(mode_bits), .STATUS_WORD(status),
    .MODE_ACTIVE(mode_act), .DRIVE_ENABLE(drive_en), .ENC_INCREMENTS(enc_inc),
    .ENC_MOTOR_REVS(enc_mrev), .GEAR_MOTOR_REVS(gear_m), .GEAR_SHAFT_REVS(gear_s));
  dso_master_model mst_u (
    .CLK(clk), .ACK(ack), .ANSWER(answer), .RDATA(rdata), .REQ(req), .WR(wr),
    .INDEX(index), .SUBIDX(subidx), .WDATA(wdata));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Read data is only judged on accepted accesses; refused reads carry none.
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic [1:0] ea, input logic [31:0] er,
                     input string nm);
    logic [1:0]  a;
    logic [31:0] r;
    mst_u.access(w, idx, sub, wd, a, r);
    chk({nm, " answer"}, {30'h0, ea}, {30'h0, a});
    if (ea === dso_pkg::ANS_OK) begin
      chk({nm, " data"}, er, r);
    end
  endtask : acc

  // A one-cycle command, then the status word two edges later; reserved bits masked.
  task automatic step(input logic [8:0] v, input logic [15:0] st, input string nm);
    @(posedge clk);
    #1 cmd_v = v;
    @(posedge clk);
    #1 cmd_v = '0;
    @(posedge clk);
    #1;
    last_exp = st | {2'b00, mode_bits, 1'b0, at_ref | halt | (st == 16'h0007), remote,
                     4'h0, power, 4'h0};
    chk(nm, {16'h0, last_exp}, {16'h0, status & 16'h3EFF});
  endtask : step

  task automatic test_reset;
    acc(1'b0, 16'h608F, 8'h00, '0, dso_pkg::ANS_OK, 32'h0000_0002, "enc count");
    acc(1'b0, 16'h6091, 8'h00, '0, dso_pkg::ANS_OK, 32'h0000_0002, "gear count");
    acc(1'b0, 16'h608F, 8'h01, '0, dso_pkg::ANS_OK, 32'h0000_00FF, "incr rst");
    acc(1'b0, 16'h608F, 8'h02, '0, dso_pkg::ANS_OK, 32'h0000_0001, "revs rst");
    acc(1'b0, 16'h6091, 8'h01, '0, dso_pkg::ANS_OK, 32'h0000_0001, "gmot rst");
    acc(1'b0, 16'h6091, 8'h02, '0, dso_pkg::ANS_OK, 32'h0000_0001, "gsha rst");
    acc(1'b0, 16'h6502, 8'h00, '0, dso_pkg::ANS_OK, 32'h0000_000D, "modes map");
    acc(1'b0, 16'h6042, 8'h00, '0, dso_pkg::ANS_NOOBJ, '0, "unmapped");
    chk("incr out", 32'h0000_00FF, enc_inc);
    chk("shaft out", 32'h0000_0001, gear_s);
    $display("test reset values done");
  endtask : test_reset

  task automatic test_modes;
    logic [7:0] code [5];
    code = '{8'h01, 8'h03, 8'h04, 8'h08, 8'h09};
    foreach (code[i]) begin
      acc(1'b1, 16'h6060, 8'h00, {24'h0, code[i]}, dso_pkg::ANS_OK, '0, "mode wr");
      acc(1'b0, 16'h6061, 8'h00, '0, dso_pkg::ANS_OK, {24'h0, code[i]}, "mode rep");
      chk("mode out", {24'h0, code[i]}, {24'h0, mode_act});
    end
    acc(1'b1, 16'h6060, 8'h00, 32'h0000_0002, dso_pkg::ANS_RANGE, '0, "mode two");
    acc(1'b1, 16'h6060, 8'h00, 32'h0000_00FF, dso_pkg::ANS_RANGE, '0, "mode neg");
    acc(1'b0, 16'h6060, 8'h00, '0, dso_pkg::ANS_OK, 32'h0000_0009, "mode kept");
    acc(1'b1, 16'h6061, 8'h00, 32'h0000_0001, dso_pkg::ANS_RDONLY, '0, "rep ro");
    $display("test mode codes done");
  endtask : test_modes

  task automatic test_units;
    logic [7:0] unit [4];
    unit = '{8'h41, 8'h42, 8'h43, 8'hFF};
    foreach (unit[i]) begin
      acc(1'b1, 16'h608F, 8'h01, {24'h0, unit[i]}, dso_pkg::ANS_OK, '0, "incr wr");
      acc(1'b0, 16'h608F, 8'h01, '0, dso_pkg::ANS_OK, {24'h0, unit[i]}, "incr rd");
      chk("incr out", {24'h0, unit[i]}, enc_inc);
    end
    acc(1'b1, 16'h608F, 8'h01, 32'h0000_0044, dso_pkg::ANS_RANGE, '0, "incr bad");
    acc(1'b1, 16'h608F, 8'h02, 32'h0000_0002, dso_pkg::ANS_RANGE, '0, "revs bad");
    acc(1'b1, 16'h6091, 8'h01, 32'h0000_0000, dso_pkg::ANS_RANGE, '0, "gmot bad");
    acc(1'b1, 16'h6091, 8'h02, 32'h0000_0003, dso_pkg::ANS_RANGE, '0, "gsha bad");
    acc(1'b1, 16'h6091, 8'h02, 32'h0000_0001, dso_pkg::ANS_OK, '0, "gsha one");
    acc(1'b1, 16'h608F, 8'h00, 32'h0000_0002, dso_pkg::ANS_RDONLY, '0, "cnt ro");
    acc(1'b1, 16'h6502, 8'h00, 32'h0000_000D, dso_pkg::ANS_RDONLY, '0, "map ro");
    acc(1'b1, 16'h6041, 8'h00, '0, dso_pkg::ANS_RDONLY, '0, "status ro");
    acc(1'b0, 16'h608F, 8'h03, '0, dso_pkg::ANS_NOOBJ, '0, "no sub three");
    acc(1'b0, 16'h608F, 8'h01, '0, dso_pkg::ANS_OK, 32'h0000_00FF, "incr kept");
    chk("revs out", 32'h0000_0001, enc_mrev);
    chk("gmot out", 32'h0000_0001, gear_m);
    $display("test unit arrays done");
  endtask : test_units

  task automatic test_states;
    logic [1:0]  a;
    logic [31:0] r;
    power = 1'b1;
    remote = 1'b1;
    mode_bits = 2'b10;
    init_done = 1'b1;
    step(9'h000, 16'h0040, "disabled");
    step(9'h001, 16'h0021, "ready");
    step(9'h002, 16'h0023, "switched on");
    step(9'h004, 16'h0027, "enabled");
    step(9'h008, 16'h0023, "disable op");
    step(9'h004, 16'h0027, "enabled again");
    step(9'h001, 16'h0021, "shutdown run");
    step(9'h002, 16'h0023, "on from ready");
    step(9'h004, 16'h0027, "run from on");
    step(9'h010, 16'h0040, "disable volt");
    step(9'h001, 16'h0021, "ready again");
    step(9'h002, 16'h0023, "on again");
    step(9'h004, 16'h0027, "run again");
    chk("drive on", 32'h1, {31'h0, drive_en});
    at_ref = 1'b1;
    power = 1'b0;
    remote = 1'b0;
    mode_bits = 2'b01;
    step(9'h000, 16'h0027, "conditions");
    at_ref = 1'b0;
    step(9'h020, 16'h0007, "quick stop");
    step(9'h004, 16'h0027, "resume");
    step(9'h020, 16'h0007, "stop again");
    step(9'h080, 16'h000F, "fault react");
    chk("drive off", 32'h0, {31'h0, drive_en});
    step(9'h100, 16'h0008, "fault");
    halt = 1'b1;
    step(9'h040, 16'h0040, "fault reset");
    mst_u.access(1'b0, 16'h6041, 8'h00, '0, a, r);
    chk("status read", {16'h0, last_exp}, r & 32'h0000_3EFF);
    $display("test drive states done");
  endtask : test_states

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The run needs about 150 cycles; twenty times that means a hang.
  initial begin
    #(8 * 3000);
    err_count++;
    print_verdict();
  end

  // Reset, then every scenario in turn.
  initial begin
    {rst_n, init_done, power, remote, at_ref, halt} = '0;
    cmd_v = '0;
    mode_bits = 2'b00;
    err_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    test_reset();
    test_modes();
    test_units();
    test_states();
    print_verdict();
  end
endmodule : tb_top
